/* File: rtl/bcc_pkg.sv */
package bcc_pkg;
	// command word field positions
	localparam int RETRY_BIT  = 31;
	localparam int MEDIA_BIT  = 30;
	localparam int PSEL_HI    = 29;
	localparam int PSEL_LO    = 26;
	localparam int CNT_HI     = 15;
	localparam int CNT_LO     = 0;
	localparam int ATM_HI     = 31;
	localparam int ATM_LO     = 16;
	localparam int AT_HI      = 15;
	localparam int AT_LO      = 0;
	// protection selector bits
	localparam int PS_STRIP   = 3;
	localparam int PS_GUARD   = 2;
	localparam int PS_APP     = 1;
	localparam int PS_REF     = 0;
	// sizes
	localparam int WORD_SHIFT = 2;
	localparam int META_DFLT  = 8;
	localparam int BLOCK_DFLT = 512;
	localparam int PAGE_DFLT  = 4096;
	localparam int PI_WORDS   = 2;
	localparam logic [1:0] PI_TYPE_NOREF = 2'h3;
	// completion status
	localparam logic [2:0] SCT_GENERIC  = 3'h0;
	localparam logic [2:0] SCT_CMD_SPEC = 3'h1;
	localparam logic [2:0] SCT_MEDIA    = 3'h2;
	localparam logic [7:0] SC_SUCCESS   = 8'h00;
	localparam logic [7:0] SC_INV_PI    = 8'h81;
	localparam logic [7:0] SC_READ_ERR  = 8'h81;
	localparam logic [7:0] SC_CMP_FAIL  = 8'h85;
	// fetch sequence steps
	localparam logic [1:0] STEP_FIRST  = 2'h0;
	localparam logic [1:0] STEP_SECOND = 2'h1;
	localparam logic [1:0] STEP_META   = 2'h2;
	localparam logic [1:0] STEP_MEDIA  = 2'h3;

	typedef enum logic [2:0] {
		BCC_IDLE    = 3'h0,
		BCC_DECODE  = 3'h1,
		BCC_FETCH   = 3'h3,
		BCC_COMPARE = 3'h2,
		BCC_DONE    = 3'h6
	} bcc_state_e;

	typedef enum logic [1:0] {
		BCC_FK_DATA = 2'h0,
		BCC_FK_LIST = 2'h1,
		BCC_FK_META = 2'h2
	} bcc_fetch_e;
endpackage

/* File: rtl/bcc_stream_if.sv */
interface bcc_stream_if #(parameter int W = 32);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/bcc_pair_buf.sv */
module bcc_pair_buf #(
	parameter int W = 32
) (
	input  wire logic  sys_clk,
	input  wire logic  rst,
	bcc_stream_if.snk  in_s,
	bcc_stream_if.src  out_s
);
	typedef struct packed {
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0]   cnt;
	} bcc_buf_s;

	localparam logic [1:0] FULL_CNT = 2'h2;

	bcc_buf_s s_r;
	bcc_buf_s s_nxt;
	logic     push;
	logic     pop;

	// handshakes; the head word always comes from a flop
	assign in_s.ready  = (s_r.cnt != FULL_CNT);
	assign out_s.valid = (s_r.cnt != 2'h0);
	assign out_s.data  = s_r.d0;
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	// two-entry queue: head in d0, tail in d1
	always_comb begin
		s_nxt = s_r;
		if (pop) begin
			s_nxt.d0 = s_r.d1;
		end
		if (push) begin
			if (s_r.cnt == 2'h0 || (s_r.cnt == 2'h1 && pop)) begin
				s_nxt.d0 = in_s.data;
			end else begin
				s_nxt.d1 = in_s.data;
			end
		end
		s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // bcc_pair_buf

/* File: rtl/bcc_compare.sv */
// Function
// - all bytes equal gives success completion
// - any miscompare gives error completion
// - metadata words are compared too
// - comparison data fetched from first pointer
// - second pointer used when two pages
// - beyond two pages second pointer is list
// - start block from words ten, eleven
// - limited retry hint from bit 31
// - force media read from bit 30
// - protection selector from bits 29:26
// - block count is field plus one
// - reference tag used only when protected
// - app tag mask used only when protected
// - app tag used only when protected
// - selector bit 3 strips protection info
// - selector bits 2:0 enable checks
// - completion posted, mismatch gives compare failure
// - invalid protection settings give status 81h
module bcc_compare
	import bcc_pkg::*;
#(
	parameter int BLOCK_BYTES = bcc_pkg::BLOCK_DFLT,
	parameter int META_BYTES  = bcc_pkg::META_DFLT,
	parameter int PAGE_BYTES  = bcc_pkg::PAGE_DFLT
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// command
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [63:0] metadata_pointer,
	input  wire logic [63:0] first_data_pointer,
	input  wire logic [63:0] second_data_pointer,
	input  wire logic [31:0] cmd_dw10,
	input  wire logic [31:0] cmd_dw11,
	input  wire logic [31:0] cmd_dw12,
	input  wire logic [31:0] cmd_dw14,
	input  wire logic [31:0] cmd_dw15,
	// namespace format
	input  wire logic        ns_pi_en,
	input  wire logic [1:0]  ns_pi_type,
	input  wire logic        ns_meta_en,
	// host memory fetch requests
	output logic             fetch_valid,
	input  wire logic        fetch_ready,
	output logic [63:0]      fetch_addr,
	output logic [31:0]      fetch_len,
	output bcc_pkg::bcc_fetch_e fetch_kind,
	// host comparison words
	input  wire logic        host_valid,
	output logic             host_ready,
	input  wire logic [31:0] host_data,
	// medium read request, read only
	output logic             media_req_valid,
	input  wire logic        media_req_ready,
	output logic [63:0]      start_block_address,
	output logic [16:0]      block_count,
	output logic             limited_retry_hint,
	output logic             force_media_read,
	output logic             protection_strip_insert,
	output logic [2:0]       protection_check_enables,
	output logic [31:0]      expected_initial_reference_tag,
	output logic [15:0]      expected_app_tag_mask,
	output logic [15:0]      expected_app_tag,
	// medium words
	input  wire logic        media_valid,
	output logic             media_ready,
	input  wire logic [31:0] media_data,
	input  wire logic        media_err,
	// completion
	output logic             cpl_valid,
	input  wire logic        cpl_ready,
	output logic [2:0]       cpl_sct,
	output logic [7:0]       cpl_sc
);
	localparam int BLOCK_WORDS = BLOCK_BYTES >> WORD_SHIFT;
	localparam int META_WORDS  = META_BYTES >> WORD_SHIFT;
	localparam int PAGE_OFF_W  = $clog2(PAGE_BYTES);
	localparam logic [31:0] PAGE_LEN = 32'(PAGE_BYTES);

	typedef struct packed {
		bcc_state_e  st;
		logic [63:0] mptr;
		logic [63:0] dptr1;
		logic [63:0] dptr2;
		logic [63:0] sblk;
		logic        retry;
		logic        fmr;
		logic        pien;
		logic        mden;
		logic [1:0]  pitype;
		logic [3:0]  psel;
		logic [16:0] nblk;
		logic [31:0] ref_tag;
		logic [15:0] atm;
		logic [15:0] at;
		logic [1:0]  step;
		logic        fv;
		logic [63:0] faddr;
		logic [31:0] flen;
		bcc_fetch_e  fkind;
		logic        mv;
		logic [31:0] words_left;
		logic        miscmp;
		logic        cv;
		logic [2:0]  sct;
		logic [7:0]  sc;
	} bcc_cmp_s;

	bcc_cmp_s    s_r;
	bcc_cmp_s    s_nxt;
	logic [31:0] data_bytes;
	logic [31:0] page_room;
	logic [31:0] first_len;
	logic [31:0] rem_bytes;
	logic [31:0] meta_per_blk;
	logic [31:0] meta_words;
	logic [31:0] tot_words;
	logic        pi_bad;
	logic        fire;
	logic        word_neq;
	logic        last_word;

	bcc_stream_if #(.W(32)) host_in ();
	bcc_stream_if #(.W(32)) host_out ();

	////////////////////////////////////////////////////////////////////////
	// host word buffer, so that a stalled medium stream loses no word
	assign host_in.valid = host_valid;
	assign host_in.data  = host_data;
	assign host_ready    = host_in.ready;

	bcc_pair_buf #(.W(32)) u_buf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.in_s    (host_in),
		.out_s   (host_out)
	);

	////////////////////////////////////////////////////////////////////////
	// transfer geometry from the latched command
	assign data_bytes = 32'(s_r.nblk) * 32'(BLOCK_BYTES);
	assign page_room  = PAGE_LEN - 32'(s_r.dptr1[PAGE_OFF_W-1:0]);
	assign first_len  = (data_bytes < page_room) ? data_bytes : page_room;
	assign rem_bytes  = data_bytes - first_len;
	// stripped protection info is not part of the host metadata
	assign meta_per_blk = !s_r.mden ? 32'h0 :
		(s_r.pien && s_r.psel[PS_STRIP]) ? 32'(META_WORDS - PI_WORDS) : 32'(META_WORDS);
	assign meta_words = 32'(s_r.nblk) * meta_per_blk;
	assign tot_words  = (data_bytes >> WORD_SHIFT) + meta_words;
	// a reference tag check on a format without reference tags is invalid
	assign pi_bad = s_r.pien && (s_r.pitype == PI_TYPE_NOREF) && s_r.psel[PS_REF];

	// a pair of words is compared when both sides offer one
	assign fire            = (s_r.st == BCC_COMPARE) && host_out.valid && media_valid;
	assign host_out.ready  = fire;
	assign media_ready     = fire;
	assign word_neq        = (host_out.data != media_data);
	assign last_word       = (s_r.words_left == 32'h1);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			BCC_IDLE: begin
				if (cmd_valid) begin
					s_nxt.st      = BCC_DECODE;
					s_nxt.mptr    = metadata_pointer;
					s_nxt.dptr1   = first_data_pointer;
					s_nxt.dptr2   = second_data_pointer;
					s_nxt.sblk    = {cmd_dw11, cmd_dw10};
					s_nxt.retry   = cmd_dw12[RETRY_BIT];
					s_nxt.fmr     = cmd_dw12[MEDIA_BIT];
					s_nxt.psel    = cmd_dw12[PSEL_HI:PSEL_LO];
					s_nxt.nblk    = {1'b0, cmd_dw12[CNT_HI:CNT_LO]} + 17'h1;
					s_nxt.pien    = ns_pi_en;
					s_nxt.mden    = ns_meta_en;
					s_nxt.pitype  = ns_pi_type;
					s_nxt.ref_tag = ns_pi_en ? cmd_dw14 : 32'h0;
					s_nxt.atm     = ns_pi_en ? cmd_dw15[ATM_HI:ATM_LO] : 16'h0;
					s_nxt.at      = ns_pi_en ? cmd_dw15[AT_HI:AT_LO] : 16'h0;
					s_nxt.miscmp  = 1'b0;
				end
			end
			BCC_DECODE: begin
				if (pi_bad) begin
					s_nxt.st  = BCC_DONE;
					s_nxt.cv  = 1'b1;
					s_nxt.sct = SCT_CMD_SPEC;
					s_nxt.sc  = SC_INV_PI;
				end else begin
					s_nxt.st         = BCC_FETCH;
					s_nxt.step       = STEP_FIRST;
					s_nxt.fv         = 1'b1;
					s_nxt.faddr      = s_r.dptr1;
					s_nxt.flen       = first_len;
					s_nxt.fkind      = BCC_FK_DATA;
					s_nxt.words_left = tot_words;
				end
			end
			BCC_FETCH: begin
				if (s_r.fv && fetch_ready) begin
					s_nxt.fv = 1'b0;
					if (s_r.step == STEP_FIRST && rem_bytes != 32'h0) begin
						s_nxt.step  = STEP_SECOND;
						s_nxt.fv    = 1'b1;
						s_nxt.faddr = s_r.dptr2;
						s_nxt.flen  = rem_bytes;
						// more than one further page: the pointer names a list
						s_nxt.fkind = (rem_bytes > PAGE_LEN) ? BCC_FK_LIST : BCC_FK_DATA;
					end else if (s_r.step != STEP_META && meta_words != 32'h0) begin
						s_nxt.step  = STEP_META;
						s_nxt.fv    = 1'b1;
						s_nxt.faddr = s_r.mptr;
						s_nxt.flen  = meta_words << WORD_SHIFT;
						s_nxt.fkind = BCC_FK_META;
					end else begin
						s_nxt.step = STEP_MEDIA;
						s_nxt.mv   = 1'b1;
					end
				end
				if (s_r.mv && media_req_ready) begin
					s_nxt.mv = 1'b0;
					s_nxt.st = BCC_COMPARE;
				end
			end
			BCC_COMPARE: begin
				if (media_err) begin
					s_nxt.st  = BCC_DONE;
					s_nxt.cv  = 1'b1;
					s_nxt.sct = SCT_MEDIA;
					s_nxt.sc  = SC_READ_ERR;
				end else if (fire) begin
					s_nxt.miscmp     = s_r.miscmp || word_neq;
					s_nxt.words_left = s_r.words_left - 32'h1;
					if (last_word) begin
						s_nxt.st  = BCC_DONE;
						s_nxt.cv  = 1'b1;
						s_nxt.sct = (s_r.miscmp || word_neq) ? SCT_MEDIA : SCT_GENERIC;
						s_nxt.sc  = (s_r.miscmp || word_neq) ? SC_CMP_FAIL : SC_SUCCESS;
					end
				end
			end
			BCC_DONE: begin
				if (cpl_ready) begin
					s_nxt.cv = 1'b0;
					s_nxt.st = BCC_IDLE;
				end
			end
			default: begin
				s_nxt.st = BCC_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from the state flops; no write path to the medium exists
	assign cmd_ready                      = (s_r.st == BCC_IDLE);
	assign fetch_valid                    = s_r.fv;
	assign fetch_addr                     = s_r.faddr;
	assign fetch_len                      = s_r.flen;
	assign fetch_kind                     = s_r.fkind;
	assign media_req_valid                = s_r.mv;
	assign start_block_address            = s_r.sblk;
	assign block_count                    = s_r.nblk;
	assign limited_retry_hint             = s_r.retry;
	assign force_media_read               = s_r.fmr;
	assign protection_strip_insert        = s_r.pien && s_r.psel[PS_STRIP];
	assign protection_check_enables       = s_r.pien ? s_r.psel[PS_GUARD:PS_REF] : 3'h0;
	assign expected_initial_reference_tag = s_r.ref_tag;
	assign expected_app_tag_mask          = s_r.atm;
	assign expected_app_tag               = s_r.at;
	assign cpl_valid                      = s_r.cv;
	assign cpl_sct                        = s_r.sct;
	assign cpl_sc                         = s_r.sc;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_success_clean: assert property (cpl_valid && cpl_sc == SC_SUCCESS
		&& cpl_sct == SCT_GENERIC |-> !s_r.miscmp)
		else $error("success reported after a miscompare");
	// a medium error in the last cycle takes priority over the compare verdict
	a_miss_fails: assert property (fire && last_word && !media_err
		&& (s_r.miscmp || word_neq)
		|=> cpl_valid && cpl_sc == SC_CMP_FAIL && cpl_sct == SCT_MEDIA)
		else $error("miscompare not reported as compare failure");
	a_meta_counted: assert property (s_r.st == BCC_DECODE && !pi_bad
		|=> s_r.words_left == $past(tot_words) && s_r.fv && s_r.faddr == s_r.dptr1)
		else $error("word count or first fetch wrong");
	a_list_long: assert property (fetch_valid && fetch_kind == BCC_FK_LIST
		|-> s_r.step == STEP_SECOND && fetch_len > PAGE_LEN)
		else $error("list fetch for a short transfer");
	a_lba_capture: assert property (cmd_valid && cmd_ready
		|=> start_block_address == $past({cmd_dw11, cmd_dw10}))
		else $error("start block not assembled from words ten and eleven");
	a_hint_capture: assert property (cmd_valid && cmd_ready
		|=> limited_retry_hint == $past(cmd_dw12[RETRY_BIT])
		&& force_media_read == $past(cmd_dw12[MEDIA_BIT]))
		else $error("retry or media hint not captured");
	a_count_plus1: assert property (cmd_valid && cmd_ready
		|=> block_count == 17'($past(cmd_dw12[CNT_HI:CNT_LO])) + 17'h1)
		else $error("block count not field plus one");
	a_pi_gated: assert property (cmd_valid && cmd_ready && !ns_pi_en
		|=> expected_initial_reference_tag == 32'h0 && expected_app_tag_mask == 16'h0
		&& expected_app_tag == 16'h0 && protection_check_enables == 3'h0)
		else $error("protection fields used without protection format");
	a_strip_gated: assert property (cmd_valid && cmd_ready
		|=> protection_strip_insert == ($past(ns_pi_en) && $past(cmd_dw12[PSEL_LO + PS_STRIP])))
		else $error("strip action not taken from selector bit three");
	a_check_sel: assert property (cmd_valid && cmd_ready && ns_pi_en
		|=> protection_check_enables == $past(cmd_dw12[PSEL_LO + PS_GUARD:PSEL_LO + PS_REF]))
		else $error("check enables not taken from selector");
	a_bad_pi: assert property (s_r.st == BCC_DECODE && pi_bad
		|=> cpl_valid && cpl_sc == SC_INV_PI && cpl_sct == SCT_CMD_SPEC && !fetch_valid)
		else $error("invalid protection settings not reported");
	a_cpl_hold: assert property (cpl_valid && !cpl_ready
		|=> cpl_valid && $stable(cpl_sc) && $stable(cpl_sct))
		else $error("completion dropped before taken");
	// the only medium request is the read issued after all fetches
	a_read_only: assert property (media_req_valid
		|-> s_r.st == BCC_FETCH && s_r.step == STEP_MEDIA)
		else $error("medium request outside the read step");

	c_success: cover property (cpl_valid && cpl_ready && cpl_sc == SC_SUCCESS);
	c_cmp_fail: cover property (cpl_valid && cpl_ready && cpl_sc == SC_CMP_FAIL);
	c_bad_pi: cover property (cpl_valid && cpl_sct == SCT_CMD_SPEC);
	c_list: cover property (fetch_valid && fetch_ready && fetch_kind == BCC_FK_LIST);
endmodule // bcc_compare

/* File: verification/bcc_far_model.sv */
////////////////////////////////////////////////////////////
// far side: host memory, host word source and medium source
module bcc_far_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        fetch_valid,
	output logic             fetch_ready,
	input  wire logic        media_req_valid,
	output logic             media_req_ready,
	output logic             host_valid,
	input  wire logic        host_ready,
	output logic [31:0]      host_data,
	output logic             media_valid,
	input  wire logic        media_ready,
	output logic [31:0]      media_data,
	output logic             media_err,
	input  wire logic [31:0] n_words,
	input  wire logic [31:0] bad_idx,
	input  wire logic [31:0] err_idx,
	input  wire logic [31:0] slow
);
	timeunit 1ns;
	timeprecision 100ps;

	// hold a word until ready was high at a rising edge; reset abandons it
	task automatic hold(input bit med);
		bit r;
		do begin
			@(negedge sys_clk) r = (med ? media_ready : host_ready) | rst;
			@(posedge sys_clk);
			#1;
		end while (!r);
	endtask

	// grant one fetch or medium request after slow idle cycles
	task automatic serve(input bit med);
		repeat (slow) @(posedge sys_clk);
		#1;
		if (med)
			media_req_ready = 1'b1;
		else
			fetch_ready = 1'b1;
		@(posedge sys_clk);
		#1;
		media_req_ready = 1'b0;
		fetch_ready = 1'b0;
	endtask

	// comparison words, one bit flipped at bad_idx
	task automatic feed_host();
		for (int i = 0; i < n_words; i++) begin
			host_valid = 1'b1;
			host_data = (32'h3c5a0000 + i) ^ {31'h0, i == bad_idx};
			hold(1'b0);
			if (rst)
				break;
		end
		host_valid = 1'b0;
		host_data = ~host_data;
	endtask

	// medium words, stalled by slow cycles each, error pulse at err_idx
	task automatic feed_media();
		for (int i = 0; i < n_words; i++) begin
			// back-to-back words keep valid up; a gap or an error drops it first
			if (slow != 0 || i == err_idx) begin
				media_valid = 1'b0;
				media_data = ~media_data;
			end
			if (slow != 0) begin
				repeat (slow) @(posedge sys_clk);
				#1;
			end
			if (i == err_idx) begin
				media_err = 1'b1;
				@(posedge sys_clk);
				#1;
				media_err = 1'b0;
				break;
			end
			media_valid = 1'b1;
			media_data = 32'h3c5a0000 + i;
			hold(1'b1);
			if (rst)
				break;
		end
		media_valid = 1'b0;
		media_data = ~media_data;
	endtask

	// answer requests; word streams start with the medium request
	initial begin
		{fetch_ready, media_req_ready, host_valid, media_valid, media_err} = 5'h0;
		host_data = 32'h0;
		media_data = 32'h0;
		forever begin
			@(negedge sys_clk);
			if (fetch_valid && !rst)
				serve(1'b0);
			else if (media_req_valid && !rst) begin
				serve(1'b1);
				fork
					feed_host();
					feed_media();
				join_none
			end
		end
	end
endmodule // bcc_far_model

/* File: verification/block_compare_command_tb.sv */
////////////////////////////////////////////////////////////
// command level bench for the compare block
module block_compare_command_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bcc_pkg::*;

	localparam int BLK = 512;
	localparam int MB  = 8;
	localparam int PG  = 4096;

	logic        sys_clk, rst, cmd_valid, cmd_ready, ns_pi_en, ns_meta_en;
	logic        fetch_valid, fetch_ready, host_valid, host_ready, media_req_valid;
	logic        media_req_ready, media_valid, media_ready, media_err, cpl_valid;
	logic        cpl_ready, limited_retry_hint, force_media_read, protection_strip_insert;
	logic [1:0]  ns_pi_type;
	logic [2:0]  protection_check_enables, cpl_sct;
	logic [7:0]  cpl_sc;
	logic [15:0] expected_app_tag_mask, expected_app_tag;
	logic [16:0] block_count;
	logic [31:0] cmd_dw10, cmd_dw11, cmd_dw12, cmd_dw14, cmd_dw15, fetch_len;
	logic [31:0] host_data, media_data, expected_initial_reference_tag;
	logic [63:0] metadata_pointer, first_data_pointer, second_data_pointer;
	logic [63:0] fetch_addr, start_block_address;
	bcc_fetch_e  fetch_kind;
	logic [97:0] fq[$];
	int          n_words, bad_idx, err_idx, slow;
	int          cyc = 0;
	int          err_total = 0;
	int          cmp_count = 0;

	bcc_compare #(.BLOCK_BYTES(BLK), .META_BYTES(MB), .PAGE_BYTES(PG)) bcc_compare_inst (
		.sys_clk, .rst, .cmd_valid, .cmd_ready, .metadata_pointer, .first_data_pointer,
		.second_data_pointer, .cmd_dw10, .cmd_dw11, .cmd_dw12, .cmd_dw14, .cmd_dw15,
		.ns_pi_en, .ns_pi_type, .ns_meta_en, .fetch_valid, .fetch_ready, .fetch_addr,
		.fetch_len, .fetch_kind, .host_valid, .host_ready, .host_data, .media_req_valid,
		.media_req_ready, .start_block_address, .block_count, .limited_retry_hint,
		.force_media_read, .protection_strip_insert, .protection_check_enables,
		.expected_initial_reference_tag, .expected_app_tag_mask, .expected_app_tag,
		.media_valid, .media_ready, .media_data, .media_err, .cpl_valid, .cpl_ready,
		.cpl_sct, .cpl_sc
	);

	bcc_far_model bcc_far_model_inst (
		.sys_clk, .rst, .fetch_valid, .fetch_ready, .media_req_valid, .media_req_ready,
		.host_valid, .host_ready, .host_data, .media_valid, .media_ready, .media_data,
		.media_err, .n_words, .bad_idx, .err_idx, .slow
	);

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// hang guard and fetch recorder
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	always @(posedge sys_clk) if (fetch_valid && fetch_ready)
		fq.push_back({fetch_kind, fetch_len, fetch_addr});

	////////////////////////////////////////////////////////////
	// comparison, verdict and handshake helpers
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic fchk(input int i, input logic [1:0] k, input logic [31:0] l,
			input logic [63:0] a);
		check(fq[i][97:96], k);
		if (l != 0)
			check(fq[i][95:64], l);
		check(fq[i][63:0], a);
	endtask

	task automatic hs(input bit cpl);
		logic r;
		do begin
			@(negedge sys_clk) r = cpl ? cpl_valid : cmd_ready;
			@(posedge sys_clk);
			#1;
		end while (r !== 1'b1);
	endtask

	task automatic do_reset();
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
	endtask

	// offer one command, await its completion, check status and latched fields
	task automatic run(input logic [63:0] a1, a2, input logic [31:0] w12,
			input int n, bad, err, sl, input logic [2:0] esct, input logic [7:0] esc);
		n_words = n;
		bad_idx = bad;
		err_idx = err;
		slow = sl;
		first_data_pointer = a1;
		second_data_pointer = a2;
		cmd_dw12 = w12;
		fq.delete();
		cmd_valid = 1'b1;
		hs(1'b0);
		cmd_valid = 1'b0;
		hs(1'b1);
		check(cpl_sct, esct);
		check(cpl_sc, esc);
		check(cmd_ready, 1'b0);
		check(start_block_address, {cmd_dw11, cmd_dw10});
		check(block_count, w12[15:0] + 17'h1);
		check(limited_retry_hint, w12[31]);
		check(force_media_read, w12[30]);
		check(protection_strip_insert, w12[29] & ns_pi_en);
		check(protection_check_enables, ns_pi_en ? w12[28:26] : 3'h0);
		check(expected_initial_reference_tag, ns_pi_en ? cmd_dw14 : 32'h0);
		check(expected_app_tag_mask, ns_pi_en ? cmd_dw15[31:16] : 16'h0);
		check(expected_app_tag, ns_pi_en ? cmd_dw15[15:0] : 16'h0);
		cpl_ready = 1'b1;
		@(posedge sys_clk);
		#1;
		cpl_ready = 1'b0;
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		{cmd_valid, cpl_ready, ns_pi_en, ns_meta_en} = 4'h0;
		ns_pi_type = 2'h0;
		metadata_pointer = 64'h7004;
		{first_data_pointer, second_data_pointer, cmd_dw12} = 160'h0;
		cmd_dw10 = 32'h89abcdef;
		cmd_dw11 = 32'h01234567;
		cmd_dw14 = 32'h11223344;
		cmd_dw15 = 32'haabbccdd;
		{n_words, bad_idx, err_idx, slow} = {32'h0, -32'sd1, -32'sd1, 32'h0};
		do_reset();
		// one block with both hints, slow medium so the buffer fills
		run(64'h1000, 64'h0, 32'hc0000000, 128, -1, -1, 2, SCT_GENERIC, SC_SUCCESS);
		check(fq.size(), 1);
		fchk(0, BCC_FK_DATA, BLK, 64'h1000);
		// seventeen blocks need a page list behind the second pointer
		run(64'h2000, 64'h9000, 32'h10, 2176, -1, -1, 0, SCT_GENERIC, SC_SUCCESS);
		check(fq.size(), 2);
		fchk(0, BCC_FK_DATA, PG, 64'h2000);
		fchk(1, BCC_FK_LIST, 0, 64'h9000);
		// two blocks over a page edge with metadata, one metadata word differs
		ns_meta_en = 1'b1;
		run(64'h3e00, 64'h5000, 32'h1, 260, 258, -1, 0, SCT_MEDIA, SC_CMP_FAIL);
		check(fq.size(), 3);
		fchk(0, BCC_FK_DATA, 512, 64'h3e00);
		fchk(1, BCC_FK_DATA, 512, 64'h5000);
		fchk(2, BCC_FK_META, 16, 64'h7004);
		do_reset();
		// every selector value on a protected namespace
		ns_pi_en = 1'b1;
		for (int s = 0; s < 16; s++) begin
			run(64'h1000, 64'h0, 32'(s) << 26, s[3] ? 128 : 130, -1, -1, 0, SCT_GENERIC,
				SC_SUCCESS);
			check(fq.size(), s[3] ? 1 : 2);
		end
		// reference check where the namespace has no reference tag
		ns_pi_type = PI_TYPE_NOREF;
		run(64'h1000, 64'h0, 32'h04000000, 0, -1, -1, 0, SCT_CMD_SPEC, SC_INV_PI);
		check(fq.size(), 0);
		// medium error part way, third reset, then a clean command
		{ns_pi_en, ns_meta_en} = 2'h0;
		run(64'h1000, 64'h0, 32'h0, 128, -1, 50, 0, SCT_MEDIA, SC_READ_ERR);
		do_reset();
		run(64'h1000, 64'h0, 32'h0, 128, -1, -1, 1, SCT_GENERIC, SC_SUCCESS);
		results();
	end
endmodule // block_compare_command_tb
